// ### verilog/boot_sysctl.sv
// Boot configuration, reset sequencing, brownout and wake control.
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.svh"

module boot_sysctl #(
	parameter int          N_EDGE    = 68,
	parameter int          N_LEVEL   = 4,
	parameter int          ADDR_PINS = 24,
	parameter int          BOOT_ADDR = 20,
	parameter logic [15:0] RST_CLKS  = `RST_HOLD_CLKS,
	parameter logic [11:0] HYST_CLKS = 12'(`HYST_CLKS)
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic                 por_active,
	input  wire logic                 reset_pin_n,
	input  wire logic                 osc_running,
	input  wire logic                 watchdog_reset_req,
	input  wire logic                 power_down_mode,
	input  wire logic                 boot_width_strap_hi,
	input  wire logic                 boot_width_strap_lo,
	input  wire logic                 brownout_detector_warn,
	input  wire logic                 brownout_detector_fail,
	input  wire logic [N_EDGE-1:0]    edge_irq_pin,
	input  wire logic [N_LEVEL-1:0]   level_irq_pin,
	output logic                      chip_reset_n,
	output logic [31:0]               boot_fetch_addr,
	output logic [1:0]                bank0_width,
	output logic [1:0]                bank1_width,
	output logic                      cs_swap,
	output logic [ADDR_PINS-1:0]      addr_pin_gpio,
	output logic [1:0]                vector_map,
	output logic                      brownout_irq_req,
	output logic                      brownout_reset_req,
	output logic [N_EDGE-1:0]         edge_irq_req,
	output logic [N_LEVEL-1:0]        level_irq_req,
	output logic                      wake_req,
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.

	localparam int SW = N_EDGE + N_LEVEL + 7;

	logic [SW-1:0]      sy;         // Synchronised pin levels.
	logic               sy_por;     // Power-on reset active.
	logic               sy_rstn;    // External reset pin, low active.
	logic               sy_osc;     // Oscillator running.
	logic [1:0]         straps;     // Width straps, high bit first.
	logic               sy_warn;    // Supply below upper threshold.
	logic               sy_fail;    // Supply below lower threshold.
	logic [N_EDGE-1:0]  sy_edge;    // Edge interrupt pins.
	logic [N_LEVEL-1:0] sy_level;   // Level interrupt pins.

	// Every pin, comparators included, crosses two flip-flops first.
	sync_2ff #(
		.W (SW)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({edge_irq_pin, level_irq_pin, por_active, reset_pin_n,
		           osc_running, boot_width_strap_hi, boot_width_strap_lo,
		           brownout_detector_warn, brownout_detector_fail}),
		.q       (sy)
	);

	assign {sy_edge, sy_level, sy_por, sy_rstn, sy_osc, straps,
	        sy_warn, sy_fail} = sy;

	// Edge and level detection for the external interrupt inputs.
	ext_irq_detect #(
		.N_EDGE  (N_EDGE),
		.N_LEVEL (N_LEVEL)
	) u_ext (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.edge_in    (sy_edge),
		.level_in   (sy_level),
		.edge_pulse (edge_irq_req),
		.level_out  (level_irq_req)
	);

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed
	{
		sysctl_pkg::rst_state_t rst;     // Reset sequencer.
		logic [15:0]            cnt;     // Release delay count.
		logic                   por_seen;// Next boot follows power-on.
		logic                   rst_n;   // Chip reset, low active.
		logic [31:0]            fetch;   // Boot fetch address.
		logic [1:0]             width;   // Latched strap width.
		logic                   swap;    // Chip select windows swapped.
		logic [ADDR_PINS-1:0]   gpio;    // Address pins left as GPIO.
		sysctl_pkg::vec_map_t   vmap;    // Vector region source.
		logic                   warn;    // Filtered upper brownout.
		logic                   fail;    // Filtered lower brownout.
		logic [11:0]            hcnt1;   // Upper hysteresis timer.
		logic [11:0]            hcnt2;   // Lower hysteresis timer.
		logic                   brst_en; // Brownout reset enabled.
		logic                   brst;    // Brownout reset request.
		logic                   wake;    // Wake request.
		logic [`EV_N-1:0]       stat;    // Sticky event bits.
		logic [`EV_N-1:0]       mask;    // Interrupt mask.
		logic [N_LEVEL:0]       wake_en; // Wake enables, top is edges.
		logic                   irq;     // Interrupt output.
		logic                   awready; // Bus write address ready.
		logic                   wready;  // Bus write data ready.
		logic                   aw_ok;   // Write address held.
		logic                   w_ok;    // Write data held.
		logic [7:0]             waddr;   // Held write address.
		logic [7:0]             wbyte;   // Held low data byte.
		logic                   wlane;   // Low byte lane enabled.
		logic                   bvalid;  // Write response pending.
		logic [1:0]             bresp;   // Write response code.
		logic                   arready; // Bus read address ready.
		logic                   rvalid;  // Read data pending.
		logic [31:0]            rdata;   // Read data.
		logic [1:0]             rresp;   // Read response code.
	} state_t;

	state_t q;
	state_t n;

	// A flag asserts at once and releases only after the supply has
	// stayed above the threshold for the whole hysteresis interval.
	function automatic logic [12:0] hyst(input logic [11:0] c,
	                                     input logic raw);
		logic [12:0] r;
		if (raw)
			r = {1'b1, HYST_CLKS};
		else if (c != 12'h000)
			r = {1'b1, c - 12'h001};
		else
			r = 13'h0000;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		logic src;
		src = 1'b0;
		n = q;

		// Brownout flags with hysteresis on both stages.
		{n.warn, n.hcnt1} = hyst(q.hcnt1, sy_warn);
		{n.fail, n.hcnt2} = hyst(q.hcnt2, sy_fail);

		// Once raised, the brownout reset ignores the enable and stays
		// up while the supply is low, so power-on reset takes over it.
		n.brst = q.fail & (q.brst_en | q.brst);

		// Any of the four sources holds the chip in reset.
		src = sy_por | ~sy_rstn | watchdog_reset_req | q.brst;
		if (sy_por)
			n.por_seen = 1'b1;

		// Reset sequencer.
		case (q.rst)
			sysctl_pkg::RST_HOLD:
			begin
				n.cnt = 16'h0000;
				if (!src && sy_osc)
					n.rst = sysctl_pkg::RST_WAIT;
			end
			sysctl_pkg::RST_WAIT:
			begin
				// Release only after the oscillator has run a full count.
				if (!sy_osc)
					n.rst = sysctl_pkg::RST_HOLD;
				else if (q.cnt == RST_CLKS - 16'h0001)
				begin
					n.rst   = sysctl_pkg::RST_RUN;
					n.rst_n = 1'b1;
					n.fetch = `BOOT_FETCH_ADDR;
					n.vmap  = sysctl_pkg::VEC_EXT;
					if (q.por_seen)
					begin
						// Straps are caught here only, never again later.
						n.width    = straps;
						n.swap     = 1'b1;
						n.por_seen = 1'b0;
						for (int i = 0; i < ADDR_PINS; i++)
							n.gpio[i] = (i >= BOOT_ADDR);
					end
				end
				else
					n.cnt = q.cnt + 16'h0001;
			end
			sysctl_pkg::RST_RUN:
			begin
				n.cnt = 16'h0000;
			end
			default:
			begin
				n.rst = sysctl_pkg::RST_HOLD;
			end
		endcase

		// A new source always restarts the sequence from hold.
		if (src)
		begin
			n.rst   = sysctl_pkg::RST_HOLD;
			n.rst_n = 1'b0;
			n.cnt   = 16'h0000;
		end

		// Wake from power-down by enabled external interrupts.
		n.wake = power_down_mode &
		         (|(sy_level & q.wake_en[N_LEVEL-1:0]) |
		          (q.wake_en[N_LEVEL] & |edge_irq_req));

		// Write response retires on its handshake.
		if (q.bvalid && bready)
			n.bvalid = 1'b0;

		// Address and data are taken independently, in either order.
		if (awvalid && q.awready)
		begin
			n.aw_ok = 1'b1;
			n.waddr = awaddr;
		end
		if (wvalid && q.wready)
		begin
			n.w_ok  = 1'b1;
			n.wbyte = wdata[7:0];
			n.wlane = wstrb[0];
		end

		// Perform the write once both halves are held.
		if (n.aw_ok && n.w_ok)
		begin
			n.aw_ok  = 1'b0;
			n.w_ok   = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = `RESP_OKAY;
			case (n.waddr)
				`REG_CTRL:
				begin
					if (n.wlane)
					begin
						// The reserved encoding leaves the map unchanged.
						if (n.wbyte[1:0] != `VEC_BAD)
							n.vmap = sysctl_pkg::vec_map_t'(n.wbyte[1:0]);
						n.swap    = n.wbyte[`CTRL_SWAP];
						n.brst_en = n.wbyte[`CTRL_RST_EN];
					end
				end
				`REG_IRQ_MASK:
				begin
					if (n.wlane)
						n.mask = n.wbyte[`EV_N-1:0];
				end
				`REG_WAKE_EN:
				begin
					if (n.wlane)
						n.wake_en = n.wbyte[N_LEVEL:0];
				end
				`REG_STATUS, `REG_IRQ_STAT:
				begin
					// Read-only registers ignore writes.
					n.bresp = `RESP_OKAY;
				end
				default:
				begin
					n.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// Read data retires on its handshake.
		if (q.rvalid && rready)
			n.rvalid = 1'b0;

		// Read: answer one cycle after the address is taken.
		if (arvalid && q.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp  = `RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			case (araddr)
				`REG_CTRL:
				begin
					n.rdata[1:0]          = q.vmap;
					n.rdata[`CTRL_SWAP]   = q.swap;
					n.rdata[`CTRL_RST_EN] = q.brst_en;
				end
				`REG_STATUS:
				begin
					n.rdata[`ST_WARN]            = q.warn;
					n.rdata[`ST_FAIL]            = q.fail;
					n.rdata[`ST_WIDTH+1:`ST_WIDTH] = q.width;
					n.rdata[`ST_BRST]            = q.brst;
					n.rdata[`ST_RUN]             = q.rst_n;
				end
				`REG_IRQ_STAT:
				begin
					// Reading clears; an event in the same cycle survives.
					n.rdata[`EV_N-1:0] = q.stat;
					n.stat             = '0;
				end
				`REG_IRQ_MASK:
				begin
					n.rdata[`EV_N-1:0] = q.mask;
				end
				`REG_WAKE_EN:
				begin
					n.rdata[N_LEVEL:0] = q.wake_en;
				end
				default:
				begin
					n.rresp = `RESP_SLVERR;
				end
			endcase
		end

		// Events set sticky bits after any clear, so the set wins.
		if (n.warn && !q.warn)
			n.stat[`EV_WARN] = 1'b1;
		if (n.fail && !q.fail)
			n.stat[`EV_FAIL] = 1'b1;
		if (n.wake && !q.wake)
			n.stat[`EV_WAKE] = 1'b1;
		n.irq = |(n.stat & n.mask);

		// Ready flags come from flops; one transfer of each kind at once.
		n.awready = !n.aw_ok && !n.bvalid;
		n.wready  = !n.w_ok && !n.bvalid;
		n.arready = !n.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset leaves the chip held in reset with a power-on boot pending.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q          <= '0;
			q.rst      <= sysctl_pkg::RST_HOLD;
			q.por_seen <= 1'b1;
		end
		else
			q <= n;
	end

	assign awready            = q.awready;
	assign wready             = q.wready;
	assign bvalid             = q.bvalid;
	assign bresp              = q.bresp;
	assign arready            = q.arready;
	assign rvalid             = q.rvalid;
	assign rdata              = q.rdata;
	assign rresp              = q.rresp;
	assign chip_reset_n       = q.rst_n;
	assign boot_fetch_addr    = q.fetch;
	// Both banks always carry the same width.
	assign bank0_width        = q.width;
	assign bank1_width        = q.width;
	assign cs_swap            = q.swap;
	assign addr_pin_gpio      = q.gpio;
	assign vector_map         = q.vmap;
	// The interrupt controller gates this with its own enable.
	assign brownout_irq_req   = q.warn;
	assign brownout_reset_req = q.brst;
	assign wake_req           = q.wake;
	assign irq                = q.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	boot_fetch_a: assert property ($rose(chip_reset_n) |->
		boot_fetch_addr == `BOOT_FETCH_ADDR)
		else $error("boot fetch address wrong");

	strap_width_a: assert property (
		$rose(chip_reset_n) && $past(q.por_seen) |->
		bank0_width == $past(straps))
		else $error("strap width not captured");

	bank_equal_a: assert property (bank0_width == bank1_width)
		else $error("bank widths differ");

	strap_hold_a: assert property (!$rose(chip_reset_n) |->
		$stable(bank0_width))
		else $error("width changed outside boot");

	cs_swap_a: assert property (
		$rose(chip_reset_n) && $past(q.por_seen) |-> cs_swap)
		else $error("windows not swapped");

	vec_ext_a: assert property ($rose(chip_reset_n) |->
		vector_map == sysctl_pkg::VEC_EXT)
		else $error("vectors not external at boot");

	warn_irq_a: assert property (sy_warn |=> brownout_irq_req)
		else $error("brownout interrupt missing");

	warn_hyst_a: assert property ($fell(sy_warn) |->
		brownout_irq_req [*8])
		else $error("brownout flag dropped early");

	brst_cause_a: assert property ($rose(brownout_reset_req) |->
		$past(q.fail) && $past(q.brst_en))
		else $error("brownout reset without cause");

	brst_hold_a: assert property (
		brownout_reset_req && q.fail |=> brownout_reset_req)
		else $error("brownout reset gap");

	rst_src_a: assert property ((sy_por || !sy_rstn ||
		watchdog_reset_req || brownout_reset_req) |=> !chip_reset_n)
		else $error("reset source ignored");

	rst_count_a: assert property ($rose(chip_reset_n) |->
		$past(q.cnt) == RST_CLKS - 16'h0001 && $past(sy_osc))
		else $error("reset released early");

	wake_pd_a: assert property (wake_req |->
		$past(power_down_mode))
		else $error("wake outside power-down");

endmodule
`default_nettype wire

// ### verilog/sysctl_defines.svh
// Constants for the boot, brownout and reset control block.
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

`define CLK_PS          5000
`define HYST_NS         10000
`define HYST_CLKS       ((`HYST_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define RST_HOLD_CLKS   16'h0400
`define BOOT_FETCH_ADDR 32'h8100_0000

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_WAKE_EN     8'h10

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define VEC_BAD         2'h3

`define CTRL_SWAP       2
`define CTRL_RST_EN     3
`define ST_WARN         0
`define ST_FAIL         1
`define ST_WIDTH        2
`define ST_BRST         4
`define ST_RUN          5
`define EV_WARN         0
`define EV_FAIL         1
`define EV_WAKE         2
`define EV_N            3

`endif

// ### verilog/sysctl_pkg.sv
// Types shared by the system control block.
package sysctl_pkg;

	// Reset sequencer states.
	typedef enum logic [1:0] {RST_HOLD, RST_WAIT, RST_RUN} rst_state_t;

	// Source of the vector region at address zero.
	typedef enum logic [1:0] {VEC_BOOT_ROM, VEC_SRAM, VEC_EXT} vec_map_t;

endpackage

// ### verilog/sync_2ff.sv
// Two flip-flop synchroniser for a bus of independent levels.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// First and second stage; the first is read only by the second.
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t r_q;
	sync_t r_d;

	// Next state is a plain shift of the two stages.
	always_comb
	begin
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	// Registered shift with synchronous reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign q = r_q.s2;

endmodule
`default_nettype wire

// ### verilog/ext_irq_detect.sv
// Edge and level detection for the external interrupt inputs.
`timescale 1ns/1ps
`default_nettype none

module ext_irq_detect #(
	parameter int N_EDGE  = 68,
	parameter int N_LEVEL = 4
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [N_EDGE-1:0]  edge_in,
	input  wire logic [N_LEVEL-1:0] level_in,
	output logic      [N_EDGE-1:0]  edge_pulse,
	output logic      [N_LEVEL-1:0] level_out
);

	// Previous input, rising pulse and level copy.
	typedef struct packed
	{
		logic [N_EDGE-1:0]  prev;
		logic [N_EDGE-1:0]  pulse;
		logic [N_LEVEL-1:0] level;
	} det_t;

	det_t r_q;
	det_t r_d;
	logic [N_EDGE-1:0] rise;

	// One rising-edge detector per edge input.
	for (genvar i = 0; i < N_EDGE; i++)
	begin : g_edge
		assign rise[i] = edge_in[i] & ~r_q.prev[i];
	end

	// Level inputs pass straight through one register.
	always_comb
	begin
		r_d.prev  = edge_in;
		r_d.pulse = rise;
		r_d.level = level_in;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign edge_pulse = r_q.pulse;
	assign level_out  = r_q.level;

endmodule
`default_nettype wire

// ### verif/board_model.sv
// Board model: supply comparators, power-on detector and boot straps.
`timescale 1ns/1ps
`default_nettype none

module board_model (
	input  wire logic        aclk,
	input  wire logic        chip_reset_n,
	input  wire logic [11:0] supply_mv,
	input  wire logic [1:0]  strap_code,
	output logic             por_active,
	output logic             warn,
	output logic             fail,
	output logic             strap_hi,
	output logic             strap_lo
);
	// Stands for data traffic on the pins that share the straps.
	logic	bus_toggle = 1'b0;

	// Comparators; the power-on detector takes over below one volt.
	assign warn       = supply_mv < 12'hB86;
	assign fail       = supply_mv < 12'hA5A;
	assign por_active = supply_mv < 12'h3E8;

	// The pattern changes every cycle so that a late sample is seen.
	always_ff @(posedge aclk)
	begin
		bus_toggle <= ~bus_toggle;
	end

	// Straps are only valid while the chip is held in reset.
	assign strap_hi = chip_reset_n ? bus_toggle : strap_code[1];
	assign strap_lo = chip_reset_n ? ~bus_toggle : strap_code[0];
endmodule
`default_nettype wire

// ### verif/boot_brownout_system_control_tb_top.sv
// Self-checking bench for the boot, brownout and reset control block.
`timescale 1ns/1ps
`default_nettype none

module boot_brownout_system_control_tb_top;
	logic	aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic	awready, wready, bvalid, arready, rvalid, chip_reset_n;
	logic	reset_pin_n, osc_running, watchdog_reset_req, power_down_mode;
	logic	por_active, strap_hi, strap_lo, warn, fail, cs_swap, irq;
	logic	brownout_irq_req, brownout_reset_req, wake_req;
	logic [7:0]	awaddr, araddr;
	logic [31:0]	wdata, rdata, boot_fetch_addr, rd;
	logic [3:0]	wstrb, level_irq_pin, level_irq_req;
	logic [1:0]	bresp, rresp, bank0_width, bank1_width, vector_map;
	logic [1:0]	strap_code;
	logic [67:0]	edge_irq_pin, edge_irq_req;
	logic [23:0]	addr_pin_gpio;
	logic [11:0]	supply_mv;
	int	fail_count, n_tests, k, n;

	// Strap setting beside the bank width it must give.
	typedef struct packed { logic [1:0] strap; logic [1:0] width; } row_t;
	row_t	rows [4] = '{'{2'h1, 2'h1}, '{2'h3, 2'h3}, '{2'h0, 2'h0},
		'{2'h2, 2'h2}};

	// Free-running 200 MHz clock.
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Long counts are shortened so the run stays brief.
	boot_sysctl #(.RST_CLKS(16'h0010), .HYST_CLKS(12'h00A)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.por_active(por_active), .reset_pin_n(reset_pin_n),
		.osc_running(osc_running),
		.watchdog_reset_req(watchdog_reset_req),
		.power_down_mode(power_down_mode),
		.boot_width_strap_hi(strap_hi), .boot_width_strap_lo(strap_lo),
		.brownout_detector_warn(warn), .brownout_detector_fail(fail),
		.edge_irq_pin(edge_irq_pin), .level_irq_pin(level_irq_pin),
		.chip_reset_n(chip_reset_n), .boot_fetch_addr(boot_fetch_addr),
		.bank0_width(bank0_width), .bank1_width(bank1_width),
		.cs_swap(cs_swap), .addr_pin_gpio(addr_pin_gpio),
		.vector_map(vector_map), .brownout_irq_req(brownout_irq_req),
		.brownout_reset_req(brownout_reset_req),
		.edge_irq_req(edge_irq_req), .level_irq_req(level_irq_req),
		.wake_req(wake_req), .irq(irq));

	board_model u_board (.aclk(aclk), .chip_reset_n(chip_reset_n),
		.supply_mv(supply_mv), .strap_code(strap_code),
		.por_active(por_active), .warn(warn), .fail(fail),
		.strap_hi(strap_hi), .strap_lo(strap_lo));

	////////////////////////////////////////////////////////////////////////

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Compares one value; case inequality so an unknown never matches.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A wait that used up its bound is a hang: count it and stop.
	task automatic bound(input int i);
		if (i >= 64)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask

	// Write: address and data offered together, each dropped when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		bound(i);
		chk(bresp, er);
		@(posedge aclk);
	endtask

	// Read: rready held until the data arrive.
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] d);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		d = rdata;
		bound(i);
		chk(rresp, er);
		@(posedge aclk);
	endtask

	// Waits for the chip to leave reset; c is the number of cycles.
	task automatic wait_boot(output int c);
		for (c = 0; c < 64; c++)
		begin
			@(posedge aclk);
			if (chip_reset_n === 1'b1) break;
		end
		bound(c);
	endtask

	////////////////////////////////////////////////////////////////////////

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{watchdog_reset_req, power_down_mode, awaddr, araddr} = '0;
		{wdata, edge_irq_pin, level_irq_pin, supply_mv} = '0;
		{reset_pin_n, osc_running, wstrb, strap_code} = {2'h3, 4'hF, 2'h0};
		fail_count = 0;
		n_tests = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(chip_reset_n, 1'b0);
		// Power-on boots, one per strap setting.
		for (k = 0; k < 4; k++)
		begin
			strap_code <= rows[k].strap;
			supply_mv <= 12'h000;
			cyc(6);
			supply_mv <= 12'hCE4;
			wait_boot(n);
			chk(bank0_width, rows[k].width);
			chk(bank1_width, rows[k].width);
			chk(boot_fetch_addr, 32'h8100_0000);
			chk(cs_swap, 1'b1);
			chk(vector_map, 2'h2);
			chk(addr_pin_gpio, 24'hF0_0000);
			axi_rd(8'h04, 2'h0, rd);
			chk(rd[3:2], rows[k].width);
		end
		// A watchdog reset is not a power-on boot: width must not move.
		strap_code <= 2'h1;
		watchdog_reset_req <= 1'b1;
		cyc(1);
		watchdog_reset_req <= 1'b0;
		cyc(2);
		chk(chip_reset_n, 1'b0);
		wait_boot(n);
		chk(bank0_width, 2'h2);
		// Reset pin released while the oscillator is still down.
		reset_pin_n <= 1'b0;
		osc_running <= 1'b0;
		cyc(6);
		reset_pin_n <= 1'b1;
		cyc(40);
		chk(chip_reset_n, 1'b0);
		osc_running <= 1'b1;
		wait_boot(n);
		chk(n inside {[16:22]}, 1'b1);
		// Vector source selection, each value in turn.
		for (k = 0; k < 3; k++)
		begin
			axi_wr(8'h00, 32'(k) | 32'h4, 2'h0);
			chk(vector_map, k[1:0]);
		end
		axi_rd(8'h40, 2'h2, rd);
		// Reserved map code, a disabled byte lane, a bad address and a read-only register.
		axi_wr(8'h00, 32'h7, 2'h0);
		chk(vector_map, 2'h2);
		wstrb <= 4'h0;
		axi_wr(8'h00, 32'h0, 2'h0);
		chk({cs_swap, vector_map}, 3'h6);
		wstrb <= 4'hF;
		axi_wr(8'h44, 32'h0, 2'h2);
		axi_wr(8'h04, 32'h0, 2'h0);
		chk(bank0_width, 2'h2);
		// Upper brownout: masked, unmasked, then read-cleared.
		axi_rd(8'h08, 2'h0, rd);
		supply_mv <= 12'hB54;
		cyc(5);
		chk(brownout_irq_req, 1'b1);
		chk(irq, 1'b0);
		axi_rd(8'h04, 2'h0, rd);
		chk(rd[0], 1'b1);
		axi_wr(8'h0C, 32'h1, 2'h0);
		cyc(2);
		chk(irq, 1'b1);
		axi_rd(8'h08, 2'h0, rd);
		chk(rd[2:0], 3'h1);
		cyc(2);
		chk(irq, 1'b0);
		supply_mv <= 12'hCE4;
		cyc(6);
		chk(brownout_irq_req, 1'b1);
		cyc(20);
		chk(brownout_irq_req, 1'b0);
		// Lower brownout with its reset disabled, then enabled.
		supply_mv <= 12'hA28;
		cyc(8);
		chk(brownout_reset_req, 1'b0);
		chk(chip_reset_n, 1'b1);
		axi_wr(8'h00, 32'hE, 2'h0);
		cyc(4);
		chk(brownout_reset_req, 1'b1);
		chk(chip_reset_n, 1'b0);
		supply_mv <= 12'h1F4;
		cyc(6);
		chk(chip_reset_n, 1'b0);
		strap_code <= 2'h3;
		supply_mv <= 12'hCE4;
		wait_boot(n);
		chk(bank1_width, 2'h3);
		// Wake from power-down by a level input, then one edge pulse.
		axi_wr(8'h10, 32'h11, 2'h0);
		// Clear old events so that only the wake event is left to see.
		axi_rd(8'h08, 2'h0, rd);
		power_down_mode <= 1'b1;
		level_irq_pin <= 4'h1;
		cyc(5);
		chk(level_irq_req, 4'h1);
		chk(wake_req, 1'b1);
		axi_rd(8'h08, 2'h0, rd);
		chk(rd[2:0], 3'h4);
		chk(irq, 1'b0);
		level_irq_pin <= 4'h0;
		edge_irq_pin[67] <= 1'b1;
		n = 0;
		for (k = 0; k < 8; k++)
		begin
			@(posedge aclk);
			if (edge_irq_req[67] === 1'b1) n++;
		end
		chk(n, 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
